// ==== hdl/ckg_defs.vh ====
// register offsets, field positions, reset values and ratios of the clock generator
`ifndef CKG_DEFS_VH
`define CKG_DEFS_VH

`define CKG_ADDR_SRC      8'h00
`define CKG_ADDR_RELOAD   8'h04
`define CKG_ADDR_CFG0     8'h08
`define CKG_ADDR_CFG1     8'h0c
`define CKG_ADDR_CARD     8'h10
`define CKG_ADDR_ALT      8'h14
`define CKG_ADDR_CONV     8'h18
`define CKG_ADDR_USB      8'h1c
`define CKG_ADDR_STATUS   8'h20

`define CKG_SRC_PLL_BIT   0
`define CKG_CFG0_DBL_BIT  0
`define CKG_CFG0_T0_BIT   1
`define CKG_CFG0_T1_BIT   2
`define CKG_CFG0_SI_BIT   4
`define CKG_CFG0_WD_BIT   6
`define CKG_CFG1_SPI_BIT  0
`define CKG_CARD_SRC_BIT  8

`define CKG_RELOAD_RST    4'hf
`define CKG_RELOAD_SPAN   5'h10
`define CKG_CARD_RST      6'h00
`define CKG_ALT_RST       2'h0
`define CKG_CONV_RST      4'h0
`define CKG_USB_RST       4'h0

`define CKG_NUM_PERIPH    5
`define CKG_DIV_W         7

`endif

// ==== hdl/ckg_tick_div.v ====
// programmable edge-tick divider with a toggled 50% clock output
`timescale 1ns/1ps
module ckg_tick_div #(
  parameter W = 7
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         tick_in,
  input  wire [W-1:0] div,
  output wire         tick_out,
  output reg          clk_out
);
  reg  [W-1:0] cnt_r;
  reg  [W-1:0] div_r;
  wire [W-1:0] div_safe;
  wire         last;

  assign div_safe = (div == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : div;
  // a new ratio loads into div_r only at the wrap, so a mid-count change waits for it
  assign last     = (cnt_r >= div_r - {{(W-1){1'b0}}, 1'b1});
  assign tick_out = tick_in & last;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= {W{1'b0}};
      div_r   <= {{(W-1){1'b0}}, 1'b1};
      clk_out <= 1'b0;
    end else if (tick_in) begin
      if (last) begin
        cnt_r   <= {W{1'b0}};
        div_r   <= div_safe;
        clk_out <= ~clk_out;
      end else begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ==== hdl/ckg_src_mux.v ====
// two-source tick selector that only switches while the fed clock is low
`timescale 1ns/1ps
module ckg_src_mux (
  input  wire pclk,
  input  wire presetn,
  input  wire sel,
  input  wire fed_clk,
  input  wire tick_a,
  input  wire tick_b,
  output wire tick_out,
  output reg  sel_r
);
  assign tick_out = sel_r ? tick_b : tick_a;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 1'b0;
    end else if (!fed_clk) begin
      // switching only while low keeps a runt high phase off the output
      sel_r <= sel;
    end
  end
endmodule

// ==== hdl/ckg_clock_gen.v ====
// clock generator top: source select, prescalers, speed modes and apb registers
//
// How it works
// - core and peripherals run from crystal or pll clock
// - source through first prescaler gives core and five peripheral clocks
// - access clock is source/(2*(16-reload)), or crystal in double speed
// - in single speed a peripheral speed bit has no effect
// - after reset core and all peripherals run single speed
// - global double speed bit switches everything at once (with pll selected the code ignores the bit and nothing switches)
// - in double speed each peripheral may return to single speed
// - single-speed peripheral under double-speed core runs at half rate
// - first prescaler divides when double speed clear, bypassed when set (with pll selected it keeps dividing)
// - first prescaler divides by two out of reset
// - card gets access clock plus pll or crystal clock via 6-bit prescaler
// - alternate card clock is peripheral clock over 1, 2, 4 or 8
// - converter clock has 50% duty cycle
// - usb side clock comes from the pll through a divider
// - source select routes pll when set, crystal when clear, resets 0
// - reload field resets to all ones
// - peripheral speed bit set selects half rate, only in double speed
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "ckg_defs.vh"
module ckg_clock_gen (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        crystal_tick,
  input  wire        pll_tick,
  output wire        core_clock,
  output wire        peripheral_access_clock,
  output wire        peripheral_access_tick,
  output wire        timer0_clock,
  output wire        timer1_clock,
  output wire        serial_port_clock,
  output wire        watchdog_clock,
  output wire        spi_clock,
  output wire        card_clock,
  output wire        alt_card_clock,
  output wire        converter_clock,
  output wire        usb_side_clock
);
  localparam DW = `CKG_DIV_W;
  localparam NP = `CKG_NUM_PERIPH;

  // software-visible state
  reg         pll_source_select_r;
  reg  [3:0]  core_reload_value_r;
  reg         double_speed_mode_r;
  reg  [NP-1:0] periph_half_r;
  reg  [5:0]  card_prescaler_r;
  reg         card_src_pll_r;
  reg  [1:0]  alt_card_prescaler_r;
  reg  [3:0]  converter_prescale_field_r;
  reg  [3:0]  usb_div_r;

  // bus decode
  wire        setup_rd;
  wire        access_wr;
  wire        mapped;
  reg  [31:0] rd_nxt;

  // clock path
  wire        src_sel_live;
  wire        src_tick;
  wire        dbl_eff;
  wire        forbidden;
  wire [4:0]  reload_span;
  wire [DW-1:0] core_div;
  wire        idle_tick;
  wire        idle_clk;
  wire [NP-1:0] periph_clk;
  wire [NP-1:0] periph_half_eff;
  wire        card_sel_live;
  wire        card_src_tick;
  wire [DW-1:0] card_div;
  wire [DW-1:0] alt_div;
  wire [DW-1:0] conv_div;
  wire [DW-1:0] usb_div;

  // ---------------- apb slave ----------------
  assign pready   = 1'b1;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign access_wr = psel & penable & pwrite;

  assign mapped = (paddr == `CKG_ADDR_SRC)    |
                  (paddr == `CKG_ADDR_RELOAD) |
                  (paddr == `CKG_ADDR_CFG0)   |
                  (paddr == `CKG_ADDR_CFG1)   |
                  (paddr == `CKG_ADDR_CARD)   |
                  (paddr == `CKG_ADDR_ALT)    |
                  (paddr == `CKG_ADDR_CONV)   |
                  (paddr == `CKG_ADDR_USB)    |
                  (paddr == `CKG_ADDR_STATUS);

  // unmapped access answers with an error and changes nothing
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_source_select_r        <= 1'b0;
      core_reload_value_r        <= `CKG_RELOAD_RST;
      double_speed_mode_r        <= 1'b0;
      periph_half_r              <= {NP{1'b0}};
      card_prescaler_r           <= `CKG_CARD_RST;
      card_src_pll_r             <= 1'b0;
      alt_card_prescaler_r       <= `CKG_ALT_RST;
      converter_prescale_field_r <= `CKG_CONV_RST;
      usb_div_r                  <= `CKG_USB_RST;
    end else if (access_wr) begin
      case (paddr)
        `CKG_ADDR_SRC: begin
          pll_source_select_r <= pwdata[`CKG_SRC_PLL_BIT];
        end
        `CKG_ADDR_RELOAD: begin
          core_reload_value_r <= pwdata[3:0];
        end
        `CKG_ADDR_CFG0: begin
          double_speed_mode_r <= pwdata[`CKG_CFG0_DBL_BIT];
          periph_half_r[0]    <= pwdata[`CKG_CFG0_T0_BIT];
          periph_half_r[1]    <= pwdata[`CKG_CFG0_T1_BIT];
          periph_half_r[2]    <= pwdata[`CKG_CFG0_SI_BIT];
          periph_half_r[3]    <= pwdata[`CKG_CFG0_WD_BIT];
        end
        `CKG_ADDR_CFG1: begin
          periph_half_r[4] <= pwdata[`CKG_CFG1_SPI_BIT];
        end
        `CKG_ADDR_CARD: begin
          card_prescaler_r <= pwdata[5:0];
          card_src_pll_r   <= pwdata[`CKG_CARD_SRC_BIT];
        end
        `CKG_ADDR_ALT: begin
          alt_card_prescaler_r <= pwdata[1:0];
        end
        `CKG_ADDR_CONV: begin
          converter_prescale_field_r <= pwdata[3:0];
        end
        `CKG_ADDR_USB: begin
          usb_div_r <= pwdata[3:0];
        end
        default: begin
          usb_div_r <= usb_div_r;
        end
      endcase
    end
  end

  // read data, prepared in the setup cycle so it leaves a flip-flop
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `CKG_ADDR_SRC: begin
        rd_nxt[`CKG_SRC_PLL_BIT] = pll_source_select_r;
      end
      `CKG_ADDR_RELOAD: begin
        rd_nxt[3:0] = core_reload_value_r;
      end
      `CKG_ADDR_CFG0: begin
        rd_nxt[`CKG_CFG0_DBL_BIT] = double_speed_mode_r;
        rd_nxt[`CKG_CFG0_T0_BIT]  = periph_half_r[0];
        rd_nxt[`CKG_CFG0_T1_BIT]  = periph_half_r[1];
        rd_nxt[`CKG_CFG0_SI_BIT]  = periph_half_r[2];
        rd_nxt[`CKG_CFG0_WD_BIT]  = periph_half_r[3];
      end
      `CKG_ADDR_CFG1: begin
        rd_nxt[`CKG_CFG1_SPI_BIT] = periph_half_r[4];
      end
      `CKG_ADDR_CARD: begin
        rd_nxt[5:0]               = card_prescaler_r;
        rd_nxt[`CKG_CARD_SRC_BIT] = card_src_pll_r;
      end
      `CKG_ADDR_ALT: begin
        rd_nxt[1:0] = alt_card_prescaler_r;
      end
      `CKG_ADDR_CONV: begin
        rd_nxt[3:0] = converter_prescale_field_r;
      end
      `CKG_ADDR_USB: begin
        rd_nxt[3:0] = usb_div_r;
      end
      `CKG_ADDR_STATUS: begin
        rd_nxt[0]   = dbl_eff;
        rd_nxt[1]   = src_sel_live;
        rd_nxt[2]   = forbidden;
        rd_nxt[3]   = card_sel_live;
        rd_nxt[8:4] = periph_half_eff;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_rd) begin
      prdata <= rd_nxt;
    end
  end

  // ---------------- core source and first prescaler ----------------
  ckg_src_mux u_core_src (
    .pclk     (pclk),
    .presetn  (presetn),
    .sel      (pll_source_select_r),
    .fed_clk  (idle_clk),
    .tick_a   (crystal_tick),
    .tick_b   (pll_tick),
    .tick_out (src_tick),
    .sel_r    (src_sel_live)
  );

  // pll with double speed is illegal; hardware keeps the divider in
  // rather than run the core at raw pll rate
  assign forbidden = double_speed_mode_r & src_sel_live;
  assign dbl_eff   = double_speed_mode_r & ~src_sel_live;

  assign reload_span = `CKG_RELOAD_SPAN - {1'b0, core_reload_value_r};
  // bypass in double speed, else 2*(16-reload); reset gives 2
  assign core_div = dbl_eff ? {{(DW-1){1'b0}}, 1'b1} : {1'b0, reload_span, 1'b0};

  ckg_tick_div #(
    .W (DW)
  ) u_core_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (src_tick),
    .div      (core_div),
    .tick_out (idle_tick),
    .clk_out  (idle_clk)
  );

  // core and register-access clocks are the same net
  assign core_clock              = idle_clk;
  assign peripheral_access_clock = idle_clk;
  assign peripheral_access_tick  = idle_tick;

  // ---------------- per-peripheral speed stages ----------------
  // speed bit only counts in double speed; single speed forces full rate
  assign periph_half_eff = periph_half_r & {NP{dbl_eff}};

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_periph
      reg half_cnt_r;
      reg half_sel_r;
      reg clk_r;
      wire step;
      // pass every tick at full rate, every second one at half rate
      assign step = idle_tick & (~half_sel_r | half_cnt_r);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          half_cnt_r <= 1'b0;
          half_sel_r <= 1'b0;
          clk_r      <= 1'b0;
        end else begin
          if (idle_tick) begin
            half_cnt_r <= ~half_cnt_r & half_sel_r;
          end
          if (step) begin
            clk_r <= ~clk_r;
          end
          // new ratio taken only at a low phase boundary
          if (idle_tick & ~half_cnt_r & ~clk_r) begin
            half_sel_r <= periph_half_eff[gi];
          end
        end
      end
      assign periph_clk[gi] = clk_r;
    end
  endgenerate

  assign timer0_clock      = periph_clk[0];
  assign timer1_clock      = periph_clk[1];
  assign serial_port_clock = periph_clk[2];
  assign watchdog_clock    = periph_clk[3];
  assign spi_clock         = periph_clk[4];

  // ---------------- card clock ----------------
  ckg_src_mux u_card_src (
    .pclk     (pclk),
    .presetn  (presetn),
    .sel      (card_src_pll_r),
    .fed_clk  (card_clock),
    .tick_a   (crystal_tick),
    .tick_b   (pll_tick),
    .tick_out (card_src_tick),
    .sel_r    (card_sel_live)
  );

  // independent of the core path; ratio limits are software's job
  assign card_div = {1'b0, card_prescaler_r} + {{(DW-1){1'b0}}, 1'b1};

  ckg_tick_div #(
    .W (DW)
  ) u_card_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (card_src_tick),
    .div      (card_div),
    .tick_out (),
    .clk_out  (card_clock)
  );

  // ---------------- alternate card clock ----------------
  assign alt_div = {{(DW-1){1'b0}}, 1'b1} << alt_card_prescaler_r;

  ckg_tick_div #(
    .W (DW)
  ) u_alt_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (idle_tick),
    .div      (alt_div),
    .tick_out (),
    .clk_out  (alt_card_clock)
  );

  // ---------------- converter clock ----------------
  // factor 2*(field+1): always even, so toggling keeps exact 50% duty
  assign conv_div = {2'b00, converter_prescale_field_r, 1'b0} +
                    {{(DW-2){1'b0}}, 2'b10};

  ckg_tick_div #(
    .W (DW)
  ) u_conv_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (crystal_tick),
    .div      (conv_div),
    .tick_out (),
    .clk_out  (converter_clock)
  );

  // ---------------- usb side clock ----------------
  assign usb_div = {3'b000, usb_div_r} + {{(DW-1){1'b0}}, 1'b1};

  ckg_tick_div #(
    .W (DW)
  ) u_usb_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick_in  (pll_tick),
    .div      (usb_div),
    .tick_out (),
    .clk_out  (usb_side_clock)
  );

endmodule

// ==== sim/ckg_chk_asserts.sv ====
// port assertions for the clock generator
`timescale 1ns/1ps
module ckg_chk (
  input wire        pclk,
  input wire        presetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        core_clock,
  input wire        peripheral_access_clock,
  input wire        peripheral_access_tick,
  input wire        timer0_clock,
  input wire        spi_clock
);
  reg       src_r;
  reg [3:0] rel_r;
  reg [6:0] cfg_r;
  wire      wr = psel && penable && pwrite;
  wire      rd = psel && !penable && !pwrite;
  wire      ok_adr = (paddr <= 8'h20) && (paddr[1:0] == 2'h0);
  // shadows follow the write edge, so a back-to-back read sees the new value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_r <= 1'b0;
      rel_r <= 4'hf;
      cfg_r <= 7'h00;
    end else begin
      src_r <= (wr && paddr == 8'h00) ? pwdata[0] : src_r;
      rel_r <= (wr && paddr == 8'h04) ? pwdata[3:0] : rel_r;
      cfg_r <= (wr && paddr == 8'h08) ? pwdata[6:0] : cfg_r;
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  core_same_a: assert property (core_clock == peripheral_access_clock)
    else $error("core and access clocks differ");
  acc_tick_a: assert property ($changed(peripheral_access_clock) |-> $past(peripheral_access_tick))
    else $error("access clock moved without a tick");
  t0_edge_a: assert property ($changed(timer0_clock) |-> $changed(peripheral_access_clock))
    else $error("timer0 clock off the access edges");
  spi_edge_a: assert property ($changed(spi_clock) |-> $changed(peripheral_access_clock))
    else $error("spi clock off the access edges");
  bad_adr_a: assert property (psel && penable && !ok_adr |-> pslverr)
    else $error("unmapped access without error");
  err_quiet_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access phase");
  rd_src_a: assert property (rd && paddr == 8'h00 |=> prdata[0] == src_r)
    else $error("source select readback wrong");
  rd_rel_a: assert property (rd && paddr == 8'h04 |=> prdata[3:0] == rel_r)
    else $error("reload readback wrong");
  rd_cfg_a: assert property (rd && paddr == 8'h08 |=> prdata[6:0] == (cfg_r & 7'h57))
    else $error("speed bits readback wrong");
endmodule

bind ckg_clock_gen ckg_chk u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
  .core_clock(core_clock), .peripheral_access_clock(peripheral_access_clock),
  .peripheral_access_tick(peripheral_access_tick), .timer0_clock(timer0_clock),
  .spi_clock(spi_clock)
);

// ==== sim/ckg_src_model.sv ====
// source model: crystal and pll edge ticks
`timescale 1ns/1ps
module ckg_src_model #(
  // 10 mhz crystal: converter field 0 lands inside its band
  parameter XP = 5,
  parameter PP = 3
) (
  input  wire pclk,
  output reg  crystal_tick,
  output reg  pll_tick
);
  integer xc;
  integer pc;
  initial begin
    crystal_tick = 1'b0;
    pll_tick = 1'b0;
    xc = 0;
    pc = 0;
  end
  // both sources run free, reset does not stop an oscillator
  always @(posedge pclk) begin
    xc <= (xc == XP - 1) ? 0 : xc + 1;
    pc <= (pc == PP - 1) ? 0 : pc + 1;
    crystal_tick <= (xc == XP - 1);
    pll_tick <= (pc == PP - 1);
  end
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the clock generator
`timescale 1ns/1ps
module tb;
  reg         pclk;
  reg         presetn;
  reg  [7:0]  paddr;
  reg         psel;
  reg         penable;
  reg         pwrite;
  reg  [31:0] pwdata;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  wire        crystal_tick;
  wire        pll_tick;
  wire [10:0] clks;
  integer     errors;
  integer     n_checks;
  integer     cyc;
  integer     i;
  reg  [31:0] rd_d;
  reg         rd_e;

  ckg_src_model u_src (.pclk(pclk), .crystal_tick(crystal_tick), .pll_tick(pll_tick));
  ckg_clock_gen DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .crystal_tick(crystal_tick), .pll_tick(pll_tick),
    .core_clock(clks[0]), .peripheral_access_clock(clks[1]),
    .peripheral_access_tick(), .timer0_clock(clks[2]), .timer1_clock(clks[3]),
    .serial_port_clock(clks[4]), .watchdog_clock(clks[5]), .spi_clock(clks[6]),
    .card_clock(clks[7]), .alt_card_clock(clks[8]), .converter_clock(clks[9]),
    .usb_side_clock(clks[10])
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task chk(input bit ok, input string m);
    n_checks = n_checks + 1;
    if (!ok) begin
      errors = errors + 1;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task apb(input bit w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_d = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ticks of the chosen source between two toggles; the first two are skipped
  // because a new ratio only loads at the divider's next wrap
  task iv(input integer k, input bit p, input integer e);
    integer n;
    reg     v;
    repeat (2) begin
      v = clks[k];
      while (clks[k] === v) @(posedge pclk);
    end
    v = clks[k];
    n = 0;
    do begin
      @(posedge pclk);
      if ((p ? pll_tick : crystal_tick) === 1'b1) n = n + 1;
    end while (clks[k] === v);
    chk(n == e, $sformatf("clock %0d interval %0d expected %0d", k, n, e));
  endtask

  task t_reset;
    apb(0, 8'h00, 32'h0);
    chk(rd_d[0] === 1'b0, "source reset");
    apb(0, 8'h04, 32'h0);
    chk(rd_d[3:0] === 4'hf, "reload reset");
    apb(0, 8'h08, 32'h0);
    chk(rd_d[6:0] === 7'h00, "speed reset");
    iv(0, 0, 2);
    for (i = 2; i < 7; i = i + 1) iv(i, 0, 2);
    $display("test reset done");
  endtask

  task t_reload;
    apb(1, 8'h04, 32'hc);
    iv(0, 0, 8);
    apb(1, 8'h00, 32'h1);
    iv(1, 1, 8);
    apb(0, 8'h20, 32'h0);
    chk(rd_d[2:0] === 3'b010, "pll live without forbidden flag");
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h04, 32'h0);
    iv(1, 0, 32);
    apb(1, 8'h04, 32'hf);
    $display("test reload done");
  endtask

  task t_speed;
    apb(1, 8'h08, 32'h56);
    apb(1, 8'h0c, 32'h1);
    apb(0, 8'h20, 32'h0);
    chk(rd_d[8:0] === 9'h000, "speed bits live in single speed");
    for (i = 2; i < 7; i = i + 1) iv(i, 0, 2);
    apb(1, 8'h08, 32'h01);
    apb(1, 8'h0c, 32'h0);
    iv(1, 0, 1);
    for (i = 2; i < 7; i = i + 1) iv(i, 0, 1);
    apb(1, 8'h08, 32'h47);
    apb(1, 8'h0c, 32'h1);
    for (i = 2; i < 7; i = i + 1) iv(i, 0, (i == 4) ? 1 : 2);
    iv(0, 0, 1);
    apb(0, 8'h20, 32'h0);
    chk(rd_d[8:0] === 9'h1b1, "effective speed status");
    apb(1, 8'h08, 32'h0);
    apb(1, 8'h0c, 32'h0);
    $display("test speed done");
  endtask

  task t_derived;
    // card near 2.5-2.8 mhz, core under 6x card: no access spacing is due
    apb(1, 8'h10, 32'h003);
    iv(7, 0, 4);
    apb(1, 8'h10, 32'h105);
    iv(7, 1, 6);
    apb(0, 8'h10, 32'h0);
    chk(rd_d[8:0] === 9'h105, "card readback");
    for (i = 0; i < 4; i = i + 1) begin
      apb(1, 8'h14, i);
      iv(8, 0, 2 << i);
    end
    // only field 0 keeps a 10 mhz crystal inside the converter band
    apb(1, 8'h18, 32'h0);
    iv(9, 0, 2);
    iv(9, 0, 2);
    iv(9, 0, 2);
    apb(1, 8'h1c, 32'h2);
    iv(10, 1, 3);
    $display("test derived done");
  endtask

  task t_bus;
    apb(1, 8'h24, 32'hff);
    chk(rd_e === 1'b1, "unmapped write error");
    apb(0, 8'h24, 32'h0);
    chk(rd_e === 1'b1 && rd_d === 32'h0, "unmapped read");
    apb(0, 8'h04, 32'h0);
    chk(rd_e === 1'b0 && rd_d[3:0] === 4'hf, "mapped read");
    $display("test bus done");
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang anywhere ends the run as a failure
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      conclude;
    end
  end

  initial begin
    errors = 0;
    n_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_reload;
    t_speed;
    t_derived;
    t_bus;
    conclude;
  end
endmodule
